// ==== flash_erase_host.sv ====
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module flash_erase_host
  import flash_host_pkg::*;
#(
  parameter int WINDOW_CYC  = `WINDOW_CYC,
  parameter int SUSPEND_CYC = `SUSPEND_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic [19:0]      FL_ADDR,
  output logic [15:0]      FL_DQ_O,
  output logic             FL_DQ_OE,
  input  wire logic [15:0] FL_DQ_I,
  output logic             FL_CE_N,
  output logic             FL_WE_N,
  output logic             FL_OE_N,
  output logic             FL_BYTE_N,
  input  wire logic        READY_BUSY_N
);

  localparam logic [15:0] WIN_LAST  = 16'(WINDOW_CYC - 1);
  localparam logic [15:0] WIN_OPEN  = 16'(WINDOW_CYC - `WIN_GUARD);
  localparam logic [15:0] SUSP_LAST = 16'(SUSPEND_CYC - 1);

  // Unlock address by mode
  function automatic logic [19:0] unlock_addr(input logic byte_m, input logic second);
    if (byte_m) begin
      unlock_addr = second ? `A_B_SECOND : `A_B_FIRST;
    end else begin
      unlock_addr = second ? `A_W_SECOND : `A_W_FIRST;
    end
  endfunction

  // Sector address, bits A18..A12 (word mode) or A19..A13 (byte mode) carry the sector number
  function automatic logic [19:0] sector_addr(input logic byte_m, input logic [6:0] sec);
    sector_addr = byte_m ? {sec, 13'h0000} : {1'b0, sec, 12'h000};
  endfunction

  // Bus cycle for a given operation and step
  function automatic flash_req_t cycle_of(input op_t op, input logic [2:0] idx,
                                          input logic byte_m, input logic [6:0] sec);
    cycle_of.wr   = 1'b1;
    cycle_of.addr = unlock_addr(byte_m, 1'b0);
    cycle_of.data = `D_RESET;
    case (op)
      OP_ERASE: begin
        case (idx)
          3'd0, 3'd3: cycle_of.data = `D_UNLOCK1;
          3'd1, 3'd4: begin
            cycle_of.addr = unlock_addr(byte_m, 1'b1);
            cycle_of.data = `D_UNLOCK2;
          end
          3'd2:    cycle_of.data = `D_SETUP;
          default: begin
            cycle_of.addr = sector_addr(byte_m, sec);
            cycle_of.data = `D_SECTOR;
          end
        endcase
      end
      OP_ADD: begin
        cycle_of.addr = sector_addr(byte_m, sec);
        cycle_of.data = `D_SECTOR;
      end
      OP_SUSPEND: cycle_of.data = `D_SUSPEND;
      OP_RESUME:  cycle_of.data = `D_RESUME;
      OP_READ: begin
        cycle_of.wr   = 1'b0;
        cycle_of.addr = sector_addr(byte_m, sec);
      end
      default: cycle_of.data = `D_RESET;
    endcase
  endfunction

  logic             byte_r, byte_nxt;
  logic [6:0]       sec_r, sec_nxt;
  phase_t           phase_r, phase_nxt;
  seq_state_t       sq_r, sq_nxt;
  op_t              op_r, op_nxt;
  logic [2:0]       idx_r, idx_nxt;
  logic [15:0]      win_r, win_nxt;
  logic [15:0]      susp_r, susp_nxt;
  logic             refused_r, refused_nxt;
  logic [7:0]       count_r, count_nxt;
  logic [15:0]      last_r, last_nxt;
  logic             pready_nxt, pslverr_nxt;
  logic [31:0]      prdata_nxt;
  logic             req_valid_r, req_valid_nxt;
  flash_req_t       req_r, req_nxt;
  logic             cyc_done;
  logic [15:0]      cyc_rdata;
  logic             wr_take, cmd_wr, accept;
  op_t              cmd_op;
  logic [2:0]       last_idx;

  assign wr_take = PSEL & PENABLE & PREADY & PWRITE;
  assign cmd_wr  = wr_take & (PADDR == `REG_CMD);
  assign cmd_op  = op_t'(PWDATA[`CMD_HI:`CMD_LO]);

  // Host-side admission of each command by phase
  always_comb begin
    accept = 1'b0;
    case (cmd_op)
      OP_ERASE:   accept = (phase_r == PH_IDLE);
      OP_ADD:     accept = (phase_r == PH_WINDOW) && (win_r < WIN_OPEN);
      OP_SUSPEND: accept = (phase_r == PH_WINDOW) || (phase_r == PH_ERASE);
      OP_RESUME:  accept = (phase_r == PH_SUSP);
      OP_READ:    accept = 1'b1;
      OP_RESET:   accept = (phase_r != PH_ERASE);
      default:    accept = 1'b0;
    endcase
  end

  // APB slave, two-cycle access, registered answer
  always_comb begin
    pready_nxt  = PSEL & PENABLE & ~PREADY;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0000_0000;
    if (PSEL & PENABLE & ~PREADY) begin
      case (PADDR)
        `REG_CTRL: begin
          prdata_nxt[`CTRL_BYTE_BIT]          = byte_r;
          prdata_nxt[`CTRL_SEC_HI:`CTRL_SEC_LO] = sec_r;
        end
        `REG_CMD: prdata_nxt[`CMD_HI:`CMD_LO] = op_r;
        `REG_STATUS: begin
          prdata_nxt[`ST_BUSY]                 = (sq_r != SQ_IDLE);
          prdata_nxt[`ST_PHASE_HI:`ST_PHASE_LO] = phase_r;
          prdata_nxt[`ST_REFUSED]              = refused_r;
          prdata_nxt[`ST_READY_BUSY]           = READY_BUSY_N;
          prdata_nxt[`ST_WINDOW]               = (phase_r == PH_WINDOW);
          prdata_nxt[`ST_COUNT_HI:`ST_COUNT_LO] = count_r;
          prdata_nxt[`ST_DATA_HI:`ST_DATA_LO]   = last_r;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  // Command sequencing and phase tracking
  always_comb begin
    byte_nxt      = byte_r;
    sec_nxt       = sec_r;
    phase_nxt     = phase_r;
    sq_nxt        = sq_r;
    op_nxt        = op_r;
    idx_nxt       = idx_r;
    win_nxt       = win_r;
    susp_nxt      = susp_r;
    refused_nxt   = refused_r;
    count_nxt     = count_r;
    last_nxt      = last_r;
    req_valid_nxt = 1'b0;
    req_nxt       = req_r;
    last_idx      = (op_r == OP_ERASE) ? (`ERASE_CYCLES - 3'd1) : 3'd0;

    if (wr_take && (PADDR == `REG_CTRL)) begin
      byte_nxt = PWDATA[`CTRL_BYTE_BIT];
      sec_nxt  = PWDATA[`CTRL_SEC_HI:`CTRL_SEC_LO];
    end
    if (wr_take && (PADDR == `REG_STATUS) && PWDATA[`ST_REFUSED]) begin
      refused_nxt = 1'b0;
    end

    // Window keeps running while a cycle is on the bus
    if (phase_r == PH_WINDOW) begin
      if (win_r == WIN_LAST) begin
        phase_nxt = PH_ERASE;
      end else begin
        win_nxt = win_r + 16'h0001;
      end
    end

    case (sq_r)
      SQ_IDLE: begin
        if (cmd_wr) begin
          if (accept && (phase_nxt == phase_r)) begin
            op_nxt  = cmd_op;
            idx_nxt = 3'd0;
            sq_nxt  = SQ_ISSUE;
          end else begin
            refused_nxt = 1'b1;
          end
        end
      end
      SQ_ISSUE: begin
        req_nxt       = cycle_of(op_r, idx_r, byte_r, sec_r);
        req_valid_nxt = 1'b1;
        sq_nxt        = SQ_WAIT;
      end
      SQ_WAIT: begin
        // Cycles follow back to back with no gap for interruption
        if (cyc_done) begin
          if (idx_r != last_idx) begin
            idx_nxt = idx_r + 3'd1;
            sq_nxt  = SQ_ISSUE;
          end else begin
            sq_nxt = SQ_IDLE;
            case (op_r)
              OP_ERASE: begin
                phase_nxt = PH_WINDOW;
                win_nxt   = 16'h0000;
                count_nxt = 8'h01;
              end
              OP_ADD: begin
                win_nxt   = 16'h0000;
                count_nxt = count_r + 8'h01;
              end
              OP_SUSPEND: begin
                if (phase_r == PH_WINDOW) begin
                  phase_nxt = PH_SUSP;
                end else begin
                  susp_nxt = 16'h0000;
                  sq_nxt   = SQ_SUSP;
                end
              end
              OP_RESUME: phase_nxt = PH_ERASE;
              OP_RESET: begin
                phase_nxt = (phase_r == PH_SUSP) ? PH_SUSP : PH_IDLE;
                count_nxt = (phase_r == PH_SUSP) ? count_r : 8'h00;
              end
              OP_READ: begin
                last_nxt = cyc_rdata;
                if (phase_r == PH_ERASE && cyc_rdata[`DQ_POLL]) begin
                  phase_nxt = PH_IDLE;
                  count_nxt = 8'h00;
                end
                if (phase_r == PH_WINDOW && cyc_rdata[`DQ_TIMER]) begin
                  phase_nxt = PH_ERASE;
                end
              end
              default: sq_nxt = SQ_IDLE;
            endcase
          end
        end
      end
      SQ_SUSP: begin
        // Wait out the longest suspend latency
        if (susp_r == SUSP_LAST) begin
          phase_nxt = PH_SUSP;
          sq_nxt    = SQ_IDLE;
        end else begin
          susp_nxt = susp_r + 16'h0001;
        end
      end
      default: sq_nxt = SQ_IDLE;
    endcase

    // Any command written while the sequencer is busy sets the sticky flag
    if (cmd_wr && sq_r != SQ_IDLE) begin
      refused_nxt = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PREADY      <= 1'b0;
      PSLVERR     <= 1'b0;
      PRDATA      <= 32'h0000_0000;
      byte_r      <= 1'b0;
      FL_BYTE_N   <= 1'b1;
      sec_r       <= 7'h00;
      phase_r     <= PH_IDLE;
      sq_r        <= SQ_IDLE;
      op_r        <= OP_NONE;
      idx_r       <= 3'd0;
      win_r       <= 16'h0000;
      susp_r      <= 16'h0000;
      refused_r   <= 1'b0;
      count_r     <= 8'h00;
      last_r      <= 16'h0000;
      req_valid_r <= 1'b0;
      req_r       <= '0;
    end else begin
      PREADY      <= pready_nxt;
      PSLVERR     <= pslverr_nxt;
      PRDATA      <= prdata_nxt;
      byte_r      <= byte_nxt;
      FL_BYTE_N   <= ~byte_nxt;
      sec_r       <= sec_nxt;
      phase_r     <= phase_nxt;
      sq_r        <= sq_nxt;
      op_r        <= op_nxt;
      idx_r       <= idx_nxt;
      win_r       <= win_nxt;
      susp_r      <= susp_nxt;
      refused_r   <= refused_nxt;
      count_r     <= count_nxt;
      last_r      <= last_nxt;
      req_valid_r <= req_valid_nxt;
      req_r       <= req_nxt;
    end
  end

  // Pin timing, strobe edges per cycle
  flash_bus_cycle u_cycle (
    .clk       (REF_CLK),
    .srst      (SRST),
    .req_valid (req_valid_r),
    .req       (req_r),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .addr      (FL_ADDR),
    .dq_o      (FL_DQ_O),
    .dq_oe     (FL_DQ_OE),
    .ce_n      (FL_CE_N),
    .we_n      (FL_WE_N),
    .oe_n      (FL_OE_N),
    .dq_i      (FL_DQ_I)
  );

endmodule

// ==== flash_host_consts.svh ====
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// Clock rate
`define REF_MHZ         100

// APB register offsets
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08

// Control fields
`define CTRL_BYTE_BIT   0
`define CTRL_SEC_LO     8
`define CTRL_SEC_HI     14

// Command field
`define CMD_LO          0
`define CMD_HI          2

// Status fields
`define ST_BUSY         0
`define ST_PHASE_LO     1
`define ST_PHASE_HI     2
`define ST_REFUSED      3
`define ST_READY_BUSY   4
`define ST_WINDOW       5
`define ST_COUNT_LO     8
`define ST_COUNT_HI     15
`define ST_DATA_LO      16
`define ST_DATA_HI      31

// Flash command data
`define D_UNLOCK1       16'h00aa
`define D_UNLOCK2       16'h0055
`define D_SETUP         16'h0080
`define D_SECTOR        16'h0030
`define D_SUSPEND       16'h00b0
`define D_RESUME        16'h0030
`define D_RESET         16'h00f0

// Unlock addresses
`define A_W_FIRST       20'h00555
`define A_W_SECOND      20'h002aa
`define A_B_FIRST       20'h00aaa
`define A_B_SECOND      20'h00555

// Sequence lengths
`define ERASE_CYCLES    3'd6

// Status bit positions read back
`define DQ_POLL         7
`define DQ_TIMER        3

// Times in ns or us and derived cycle counts
`define T_WP_NS         35
`define T_WPH_NS        20
`define T_ACC_NS        70
`define T_WINDOW_US     50
`define T_SUSPEND_US    20
`define WP_CYC          ((`T_WP_NS * `REF_MHZ + 999) / 1000)
`define WPH_CYC         ((`T_WPH_NS * `REF_MHZ + 999) / 1000)
`define ACC_CYC         ((`T_ACC_NS * `REF_MHZ + 999) / 1000)
`define WINDOW_CYC      (`T_WINDOW_US * `REF_MHZ)
`define SUSPEND_CYC     (`T_SUSPEND_US * `REF_MHZ)
// Margin before window end, covers command to strobe delay
`define WIN_GUARD       16

`endif

// ==== flash_host_pkg.sv ====
package flash_host_pkg;

  typedef struct packed {
    logic        wr;
    logic [19:0] addr;
    logic [15:0] data;
  } flash_req_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_WINDOW = 2'b01,
    PH_ERASE  = 2'b10,
    PH_SUSP   = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_ERASE   = 3'b001,
    OP_ADD     = 3'b010,
    OP_SUSPEND = 3'b011,
    OP_RESUME  = 3'b100,
    OP_READ    = 3'b101,
    OP_RESET   = 3'b110
  } op_t;

  typedef enum logic [1:0] {
    SQ_IDLE  = 2'b00,
    SQ_ISSUE = 2'b01,
    SQ_WAIT  = 2'b10,
    SQ_SUSP  = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    CY_IDLE   = 2'b00,
    CY_SETUP  = 2'b01,
    CY_STROBE = 2'b10,
    CY_HOLD   = 2'b11
  } cyc_state_t;

endpackage

// ==== flash_bus_cycle.sv ====
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int WP_CYC  = `WP_CYC,
  parameter int WPH_CYC = `WPH_CYC,
  parameter int ACC_CYC = `ACC_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        req_valid,
  input  wire flash_req_t  req,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [19:0]      addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  input  wire logic [15:0] dq_i
);

  cyc_state_t  st_r, st_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        wr_r, wr_nxt;
  logic        done_nxt, dq_oe_nxt, ce_n_nxt, we_n_nxt, oe_n_nxt;
  logic [15:0] rdata_nxt, dq_o_nxt;
  logic [19:0] addr_nxt;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    wr_nxt    = wr_r;
    done_nxt  = 1'b0;
    rdata_nxt = rdata;
    addr_nxt  = addr;
    dq_o_nxt  = dq_o;
    dq_oe_nxt = dq_oe;
    ce_n_nxt  = ce_n;
    we_n_nxt  = we_n;
    oe_n_nxt  = oe_n;
    case (st_r)
      CY_IDLE: begin
        if (req_valid) begin
          addr_nxt  = req.addr;
          dq_o_nxt  = req.data;
          wr_nxt    = req.wr;
          dq_oe_nxt = req.wr;
          ce_n_nxt  = 1'b0;
          st_nxt    = CY_SETUP;
        end
      end
      CY_SETUP: begin
        // Address latched at falling strobe edge
        if (wr_r) begin
          we_n_nxt = 1'b0;
          cnt_nxt  = 8'(WP_CYC);
        end else begin
          oe_n_nxt = 1'b0;
          cnt_nxt  = 8'(ACC_CYC);
        end
        st_nxt = CY_STROBE;
      end
      CY_STROBE: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          // Data latched at rising strobe edge
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (!wr_r) begin
            rdata_nxt = dq_i;
          end
          cnt_nxt = 8'(WPH_CYC);
          st_nxt  = CY_HOLD;
        end
      end
      CY_HOLD: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          ce_n_nxt  = 1'b1;
          dq_oe_nxt = 1'b0;
          done_nxt  = 1'b1;
          st_nxt    = CY_IDLE;
        end
      end
      default: st_nxt = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r  <= CY_IDLE;
      cnt_r <= 8'h00;
      wr_r  <= 1'b0;
      done  <= 1'b0;
      rdata <= 16'h0000;
      addr  <= 20'h00000;
      dq_o  <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n  <= 1'b1;
      we_n  <= 1'b1;
      oe_n  <= 1'b1;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r  <= wr_nxt;
      done  <= done_nxt;
      rdata <= rdata_nxt;
      addr  <= addr_nxt;
      dq_o  <= dq_o_nxt;
      dq_oe <= dq_oe_nxt;
      ce_n  <= ce_n_nxt;
      we_n  <= we_n_nxt;
      oe_n  <= oe_n_nxt;
    end
  end

endmodule

// ==== flash_erase_host_checker.sv ====
`timescale 1ns/1ps

module flash_erase_host_checker (
  input wire logic        REF_CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [19:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_O,
  input wire logic        FL_DQ_OE,
  input wire logic        FL_CE_N,
  input wire logic        FL_WE_N,
  input wire logic        FL_OE_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  sequence apb_wait_s;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence we_pulse_s;
    !FL_WE_N [*4] ##1 FL_WE_N;
  endsequence
  sequence hold_s;
    (!FL_CE_N && FL_DQ_OE) [*2] ##1 (FL_CE_N && !FL_DQ_OE);
  endsequence

  pready_time_a: assert property (apb_wait_s |=> PREADY) else $error("late ready");
  pready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
  slverr_map_a: assert property (apb_wait_s |=> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08}))
    else $error("wrong error flag");
  err_data_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("error data");
  we_width_a: assert property ($fell(FL_WE_N) |-> we_pulse_s) else $error("write width");
  ce_setup_a: assert property ($fell(FL_WE_N) |-> !$past(FL_CE_N) && FL_DQ_OE)
    else $error("no setup");
  write_hold_a: assert property (!FL_WE_N && !$fell(FL_WE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_O))
    else $error("write moved");
  data_hold_a: assert property ($rose(FL_WE_N) |-> hold_s) else $error("hold broken");
  strobe_excl_a: assert property (!FL_WE_N |-> FL_OE_N && !FL_CE_N) else $error("strobe clash");
  bus_turn_a: assert property (!FL_OE_N |-> !FL_DQ_OE) else $error("drive during read");
  reset_idle_a: assert property (disable iff (1'b0) SRST |=> FL_CE_N && FL_WE_N && !PREADY)
    else $error("reset state");
endmodule

bind flash_erase_host flash_erase_host_checker u_chk (
  .REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O),
  .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N)
);

// ==== flash_dev_model.sv ====
`timescale 1ns/1ps

module flash_dev_model #(
  parameter int WIN_NS   = 2000,
  parameter int ERASE_NS = 3000
) (
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_w,
  output logic [15:0]      dq_r,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        byte_n,
  output logic             ready_busy_n
);
  logic [1:0]   st = 2'd0;
  logic [2:0]   step = 3'd0;
  logic [127:0] sel = '0;
  logic [19:0]  la = '0;
  logic [15:0]  last = '0;
  logic         tog = 1'b0;
  time          t0 = 0;
  time          rem = 0;
  logic [19:0]  wa[$];
  logic [15:0]  wd[$];
  logic [7:0]   dtab[5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
  wire          drv = !ce_n && !oe_n;
  wire  [15:0]  rdv;

  function automatic logic [6:0] sec_of(input logic [19:0] a);
    return byte_n ? a[18:12] : a[19:13];
  endfunction
  function automatic logic unl(input logic [19:0] a, input logic first);
    if (byte_n) return a[10:0] == (first ? 11'h555 : 11'h2aa);
    return a[11:0] == (first ? 12'haaa : 12'h555);
  endfunction

  task automatic write_cycle(input logic [19:0] a, input logic [15:0] d);
    wa.push_back(a);
    wd.push_back(d);
    case (st)
      2'd0: begin
        if (step < 5 && unl(a, step != 1 && step != 4) && d[7:0] == dtab[step]) begin
          step = step + 3'd1;
        end else if (step == 5 && d[7:0] == 8'h30) begin
          sel[sec_of(a)] = 1'b1;
          st = 2'd1;
          t0 = $time;
          step = 3'd0;
        end else begin
          step = 3'd0;
        end
      end
      2'd1: begin
        if (d[7:0] == 8'h30) begin
          sel[sec_of(a)] = 1'b1;
          t0 = $time;
        end else if (d[7:0] == 8'hb0) begin
          rem = ERASE_NS;
          st = 2'd3;
        end else begin
          st = 2'd0;
          sel = '0;
        end
      end
      2'd2: if (d[7:0] == 8'hb0) begin
        rem = t0 - $time;
        st = 2'd3;
      end
      default: if (d[7:0] == 8'h30) begin
        t0 = $time + rem;
        st = 2'd2;
      end
    endcase
  endtask

  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) write_cycle(la, dq_w);
  always #10 begin
    if (st == 2'd1 && $time - t0 >= WIN_NS) begin
      st = 2'd2;
      t0 = $time + ERASE_NS;
    end else if (st == 2'd2 && $time >= t0) begin
      st = 2'd0;
      sel = '0;
    end
  end
  always @(negedge oe_n) tog = ~tog;
  assign rdv = (st == 2'd1 || st == 2'd2) ? {9'h0, tog, 2'b00, st == 2'd2, 3'b000} :
               (st == 2'd3 && sel[sec_of(addr)]) ? 16'h0080 : 16'h3cda;
  always @(drv or rdv) if (drv) last = rdv;
  assign dq_r = drv ? rdv : ~last;
  assign ready_busy_n = (st != 2'd2);
endmodule

// ==== tb_flash_erase_host.sv ====
`timescale 1ns/1ps
`include "flash_host_consts.svh"
`define CHECK_EQ(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_flash_erase_host;
  import flash_host_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, fl_dq_oe, ce_n, we_n, oe_n, byte_n, rbn, err;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_o, dev_dq, fl_dq_i;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [11:0] wtab[5] = '{12'h555, 12'h2aa, 12'h555, 12'h555, 12'h2aa};
  logic [11:0] btab[5] = '{12'haaa, 12'h555, 12'haaa, 12'haaa, 12'h555};
  logic [15:0] dtab[6] = '{16'h00aa, 16'h0055, 16'h0080, 16'h00aa, 16'h0055, 16'h0030};

  assign fl_dq_i = fl_dq_oe ? fl_dq_o : dev_dq;
  flash_erase_host #(.WINDOW_CYC(200), .SUSPEND_CYC(50)) u_dut (
    .REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FL_ADDR(fl_addr), .FL_DQ_O(fl_dq_o), .FL_DQ_OE(fl_dq_oe), .FL_DQ_I(fl_dq_i),
    .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n), .FL_BYTE_N(byte_n), .READY_BUSY_N(rbn));
  flash_dev_model #(.WIN_NS(2000), .ERASE_NS(3000)) u_flash (
    .addr(fl_addr), .dq_w(fl_dq_i), .dq_r(dev_dq), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .byte_n(byte_n), .ready_busy_n(rbn));

  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cmd(input op_t op);
    int n;
    n = 0;
    apb(1'b1, `REG_CMD, {29'h0, op});
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
      n++;
    end while (rd[`ST_BUSY] !== 1'b0 && n < 50);
  endtask

  task automatic set_ctrl(input logic b, input logic [6:0] s);
    apb(1'b1, `REG_CTRL, {17'h0, s, 7'h0, b});
  endtask

  task automatic rd_sec(input logic b, input logic [6:0] s);
    set_ctrl(b, s);
    cmd(OP_READ);
  endtask

  task automatic wait_phase(input phase_t p, input int tries);
    int n;
    n = 0;
    apb(1'b0, `REG_STATUS, 32'h0);
    while (rd[2:1] !== p && n < tries) begin
      apb(1'b0, `REG_STATUS, 32'h0);
      n++;
    end
  endtask

  task automatic wait_done(input logic b, input logic [6:0] s);
    int n;
    n = 0;
    do begin
      rd_sec(b, s);
      n++;
    end while (rd[2:1] !== PH_IDLE && n < 40);
    `CHECK_EQ(rd[2:1], PH_IDLE)
    `CHECK_EQ(u_flash.sel, 128'h0)
  endtask

  task automatic t_regs();
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHECK_EQ(rd, 32'h0)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHECK_EQ(rd[5:0], 6'h10)
    apb(1'b0, 8'h0c, 32'h0);
    `CHECK_EQ({err, rd}, 33'h1_0000_0000)
    apb(1'b1, 8'h10, 32'hffff_ffff);
    `CHECK_EQ(err, 1'b1)
    set_ctrl(1'b0, 7'h05);
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHECK_EQ(rd, 32'h0000_0500)
    apb(1'b1, `REG_CMD, 32'h0);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHECK_EQ(rd[`ST_REFUSED], 1'b1)
    apb(1'b1, `REG_STATUS, 32'h8);
    $display("test regs done");
  endtask

  task automatic t_word();
    u_flash.wa.delete();
    u_flash.wd.delete();
    set_ctrl(1'b0, 7'h05);
    cmd(OP_ERASE);
    `CHECK_EQ(u_flash.wa.size(), 6)
    for (int i = 0; i < 6; i++) begin
      `CHECK_EQ(u_flash.wd[i], dtab[i])
      if (i < 5) `CHECK_EQ(u_flash.wa[i][11:0], wtab[i])
    end
    `CHECK_EQ(u_flash.wa[5][18:12], 7'h05)
    `CHECK_EQ({rd[2:1], rd[`ST_WINDOW]}, {PH_WINDOW, 1'b1})
    set_ctrl(1'b0, 7'h09);
    cmd(OP_ADD);
    set_ctrl(1'b0, 7'h02);
    cmd(OP_ADD);
    `CHECK_EQ({u_flash.sel[9], u_flash.sel[5], u_flash.sel[2]}, 3'b111)
    `CHECK_EQ(rd[`ST_COUNT_HI:`ST_COUNT_LO], 8'h03)
    wait_phase(PH_ERASE, 100);
    `CHECK_EQ(rd[2:1], PH_ERASE)
    rd_sec(1'b0, 7'h05);
    `CHECK_EQ({rd[23], rd[19], rd[`ST_READY_BUSY]}, 3'b010)
    cmd(OP_SUSPEND);
    wait_phase(PH_SUSP, 60);
    `CHECK_EQ(rd[2:1], PH_SUSP)
    `CHECK_EQ(u_flash.st, 2'd3)
    rd_sec(1'b0, 7'h02);
    `CHECK_EQ(rd[31:16], 16'h0080)
    rd_sec(1'b0, 7'h07);
    `CHECK_EQ(rd[31:16], 16'h3cda)
    cmd(OP_RESUME);
    `CHECK_EQ(u_flash.st, 2'd2)
    cmd(OP_RESUME);
    `CHECK_EQ(rd[`ST_REFUSED], 1'b1)
    apb(1'b1, `REG_STATUS, 32'h8);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHECK_EQ(rd[`ST_REFUSED], 1'b0)
    wait_done(1'b0, 7'h05);
    $display("test word erase done");
  endtask

  task automatic t_byte();
    u_flash.wa.delete();
    set_ctrl(1'b1, 7'h03);
    cmd(OP_ERASE);
    for (int i = 0; i < 5; i++) `CHECK_EQ(u_flash.wa[i][11:0], btab[i])
    `CHECK_EQ(u_flash.wa[5][19:13], 7'h03)
    cmd(OP_SUSPEND);
    `CHECK_EQ({rd[2:1], u_flash.st}, {PH_SUSP, 2'd3})
    cmd(OP_RESET);
    `CHECK_EQ({rd[2:1], u_flash.st}, {PH_SUSP, 2'd3})
    cmd(OP_RESUME);
    wait_done(1'b1, 7'h03);
    $display("test byte suspend done");
  endtask

  task automatic t_abort();
    set_ctrl(1'b0, 7'h04);
    cmd(OP_SUSPEND);
    `CHECK_EQ(rd[`ST_REFUSED], 1'b1)
    apb(1'b1, `REG_STATUS, 32'h8);
    cmd(OP_ERASE);
    cmd(OP_RESET);
    `CHECK_EQ({rd[2:1], u_flash.st, u_flash.sel[4]}, {PH_IDLE, 2'd0, 1'b0})
    cmd(OP_ERASE);
    cmd(OP_ERASE);
    `CHECK_EQ(rd[`ST_REFUSED], 1'b1)
    wait_done(1'b0, 7'h04);
    apb(1'b0, `REG_CMD, 32'h0);
    `CHECK_EQ(rd, 32'h0000_0005)
    $display("test abort done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_word();
    t_byte();
    t_abort();
    print_verdict();
  end
endmodule
